/* File: include/nsx_defines.svh */
// Purpose: offsets, field positions and reset values for the nibble/skip/table/xor executor
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   byte addresses
`ifndef NSX_DEFINES_SVH
`define NSX_DEFINES_SVH

`define NSX_OFS_CMD      12'h000
`define NSX_OFS_STAT     12'h004
`define NSX_OFS_ACCUM    12'h008
`define NSX_OFS_TPTR_LO  12'h00c
`define NSX_OFS_TPTR_HI  12'h010
`define NSX_OFS_TLATCH   12'h014
`define NSX_OFS_PC       12'h018
`define NSX_OFS_DMEM     12'h040

`define NSX_CMD_OP_LSB   0
`define NSX_CMD_ADDR_LSB 4
`define NSX_CMD_BIT_LSB  12
`define NSX_CMD_IMM_LSB  16

`define NSX_STAT_BUSY    0
`define NSX_STAT_ZERO    1
`define NSX_STAT_SKIP    2

`define NSX_RST_BYTE     8'h00
`define NSX_PAGE_BITS    8

`endif

/* File: include/nsx_pkg.sv */
// Purpose: types shared by the executor
// Assumes: nothing beyond nsx_defines.svh
// Notes:   op codes follow enum order
package nsx_pkg;

  typedef enum logic [3:0] {
    NSX_OP_SWAP,
    NSX_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR,
    NSX_OP_SKIP_WHEN_NULL,
    NSX_OP_MOVE_AND_SKIP_WHEN_NULL,
    NSX_OP_SKIP_WHEN_BIT_NULL,
    NSX_OP_TABLE_READ_SPECIFIC_PAGE,
    NSX_OP_TABLE_READ_CURRENT_PAGE,
    NSX_OP_TABLE_READ_LAST_PAGE,
    NSX_OP_XOR_TO_ACCUMULATOR,
    NSX_OP_EXCLUSIVE_OR_INTO_MEMORY,
    NSX_OP_XOR_IMMEDIATE
  } nsx_op_e;

  typedef struct packed {
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    nsx_op_e    op;
  } nsx_cmd_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } nsx_apb_req_s;

  typedef enum logic [1:0] {
    NSX_ST_IDLE,
    NSX_ST_EXEC,
    NSX_ST_TABLE,
    NSX_ST_DUMMY
  } nsx_state_e;

endpackage : nsx_pkg

/* File: core/nsx_exec.sv */
// Purpose: executes one instruction at a time from an APB command register
// Assumes: program memory answers on pm_rvalid in the pclk domain
// Notes:   data memory is internal flip-flops, reachable over APB while idle
// Functional notes
// - swap in place exchanges the two nibbles of the data byte, flags unchanged.
// - swap to accumulator loads crossed nibbles into accumulator; data and flags unchanged.
// - byte test skips the next instruction when the data byte is zero.
// - every skip adds one dummy cycle, so the test takes two instruction cycles.
// - move-and-test copies the byte to accumulator and skips when it is zero.
// - bit test skips when the selected bit is zero, flags unchanged.
// - specific-page table read uses upper and lower pointers; low to memory, high to latch.
// - current-page table read uses lower pointer inside the current program page.
// - last-page table read uses lower pointer inside the final program page.
// - xor with memory into accumulator; only the zero flag changes.
// - xor of memory with accumulator written back to memory; only zero flag changes.
// - xor with immediate into accumulator; only the zero flag changes.
`timescale 1ns/1ps
`include "nsx_defines.svh"

module nsx_exec #(
  parameter int DM_DEPTH = 16,
  parameter int PA_W     = 12
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire nsx_pkg::nsx_apb_req_s apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // program memory read port
  output logic [PA_W-1:0]            pm_addr,
  output logic                       pm_rd,
  input  wire logic [15:0]           pm_rdata,
  input  wire logic                  pm_rvalid,
  // status
  output logic                       busy
);
  import nsx_pkg::*;

  localparam int DM_AW = $clog2(DM_DEPTH);
  localparam int HP_W  = PA_W - `NSX_PAGE_BITS;

  nsx_state_e       state_q, state_d;
  nsx_cmd_s         cmd_q;
  logic [7:0]       accum_q;
  logic             zero_q;
  logic             skip_q;
  logic [7:0]       tptr_lo_q;
  logic [HP_W-1:0]  tptr_hi_q;
  logic [7:0]       tlatch_q;
  logic [PA_W-1:0]  pc_q;
  logic [PA_W-1:0]  pm_addr_q;
  logic             pm_rd_q;
  logic [7:0]       dmem_q [DM_DEPTH];

  // apb decode
  wire logic             apb_xfer   = apb_req.psel & apb_req.penable;
  wire logic             apb_wr     = apb_xfer & apb_req.pwrite;
  wire logic [11:0]      apb_addr   = apb_req.paddr;
  wire logic             idle       = (state_q == NSX_ST_IDLE);
  wire logic             hit_cmd    = (apb_addr == `NSX_OFS_CMD);
  wire logic             hit_stat   = (apb_addr == `NSX_OFS_STAT);
  wire logic             hit_accum  = (apb_addr == `NSX_OFS_ACCUM);
  wire logic             hit_tlo    = (apb_addr == `NSX_OFS_TPTR_LO);
  wire logic             hit_thi    = (apb_addr == `NSX_OFS_TPTR_HI);
  wire logic             hit_tlatch = (apb_addr == `NSX_OFS_TLATCH);
  wire logic             hit_pc     = (apb_addr == `NSX_OFS_PC);
  wire logic [11:0]      dm_rel     = apb_addr - `NSX_OFS_DMEM;
  wire logic             hit_dmem   = (apb_addr >= `NSX_OFS_DMEM) && (dm_rel[1:0] == 2'b00)
                                      && (dm_rel[11:2] < 10'(DM_DEPTH));
  wire logic [DM_AW-1:0] dm_apb_idx = dm_rel[DM_AW+1:2];
  wire logic             hit_any    = hit_cmd | hit_stat | hit_accum | hit_tlo | hit_thi
                                      | hit_tlatch | hit_pc | hit_dmem;
  // writes are refused while busy; writes to the status and latch words are refused always
  wire logic             wr_ok      = idle & ~hit_stat & ~hit_tlatch;
  wire logic             sw_wr      = apb_wr & hit_any & wr_ok;
  wire logic             launch     = sw_wr & hit_cmd;

  assign pready  = 1'b1;
  assign pslverr = apb_xfer & (~hit_any | (apb_req.pwrite & ~wr_ok));
  assign busy    = ~idle;
  assign pm_addr = pm_addr_q;
  assign pm_rd   = pm_rd_q;

  // execution datapath
  wire logic [DM_AW-1:0] dm_idx    = cmd_q.addr[DM_AW-1:0];
  wire logic [7:0]       mem_byte  = dmem_q[dm_idx];
  wire logic [7:0]       swapped   = {mem_byte[3:0], mem_byte[7:4]};
  wire logic [7:0]       xor_mem   = accum_q ^ mem_byte;
  wire logic [7:0]       xor_imm   = accum_q ^ cmd_q.imm;
  wire logic             byte_null = (mem_byte == `NSX_RST_BYTE);
  wire logic             bit_null  = ~mem_byte[cmd_q.bit_sel];
  wire logic             exec      = (state_q == NSX_ST_EXEC);
  wire logic             op_swap   = cmd_q.op == NSX_OP_SWAP;
  wire logic             op_nibx   = cmd_q.op == NSX_OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR;
  wire logic             op_skz    = cmd_q.op == NSX_OP_SKIP_WHEN_NULL;
  wire logic             op_mskz   = cmd_q.op == NSX_OP_MOVE_AND_SKIP_WHEN_NULL;
  wire logic             op_skbit  = cmd_q.op == NSX_OP_SKIP_WHEN_BIT_NULL;
  wire logic             op_tabs   = cmd_q.op == NSX_OP_TABLE_READ_SPECIFIC_PAGE;
  wire logic             op_tabc   = cmd_q.op == NSX_OP_TABLE_READ_CURRENT_PAGE;
  wire logic             op_tabl   = cmd_q.op == NSX_OP_TABLE_READ_LAST_PAGE;
  wire logic             op_xora   = cmd_q.op == NSX_OP_XOR_TO_ACCUMULATOR;
  wire logic             op_exclusive_or_into_memory   = cmd_q.op == NSX_OP_EXCLUSIVE_OR_INTO_MEMORY;
  wire logic             op_xori   = cmd_q.op == NSX_OP_XOR_IMMEDIATE;
  wire logic             op_table  = op_tabs | op_tabc | op_tabl;
  wire logic             do_skip   = ((op_skz | op_mskz) & byte_null) | (op_skbit & bit_null);
  wire logic             xor_to_a  = op_xora | op_xori;
  wire logic [7:0]       xor_res   = op_xori ? xor_imm : xor_mem;
  wire logic             xor_any   = xor_to_a | op_exclusive_or_into_memory;

  // table address: page from pointer, current pc, or all ones
  wire logic [HP_W-1:0]  page_cur  = pc_q[PA_W-1:`NSX_PAGE_BITS];
  wire logic [HP_W-1:0]  page_sel  = op_tabs ? tptr_hi_q :
                                     op_tabc ? page_cur :
                                               {HP_W{1'b1}};
  wire logic [PA_W-1:0]  tab_addr  = {page_sel, tptr_lo_q};
  wire logic             tab_done  = (state_q == NSX_ST_TABLE) & pm_rvalid;

  // one write port into data memory; execution and table return outrank software
  logic             dm_we;
  logic [7:0]       dm_wdata;
  logic [DM_AW-1:0] dm_widx;
  always_comb
  begin
    dm_we    = 1'b0;
    dm_wdata = apb_req.pwdata[7:0];
    dm_widx  = dm_apb_idx;
    if (exec & (op_swap | op_exclusive_or_into_memory))
    begin
      dm_we    = 1'b1;
      dm_wdata = op_swap ? swapped : xor_mem;
      dm_widx  = dm_idx;
    end
    else if (tab_done)
    begin
      dm_we    = 1'b1;
      dm_wdata = pm_rdata[7:0];
      dm_widx  = dm_idx;
    end
    else if (sw_wr & hit_dmem)
    begin
      dm_we    = 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DM_DEPTH; gi++)
    begin : g_dmem
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          dmem_q[gi] <= `NSX_RST_BYTE;
        else if (dm_we && (dm_widx == DM_AW'(gi)))
          dmem_q[gi] <= dm_wdata;
      end
    end
  endgenerate

  // sequencer
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      NSX_ST_IDLE:  state_d = launch ? NSX_ST_EXEC : NSX_ST_IDLE;
      NSX_ST_EXEC:  state_d = op_table ? NSX_ST_TABLE : (do_skip ? NSX_ST_DUMMY : NSX_ST_IDLE);
      NSX_ST_TABLE: state_d = pm_rvalid ? NSX_ST_IDLE : NSX_ST_TABLE;
      NSX_ST_DUMMY: state_d = NSX_ST_IDLE;
      default:      state_d = NSX_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= NSX_ST_IDLE;
      cmd_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      // fields are picked by register position; the struct packs them tighter
      if (launch)
      begin
        cmd_q.op      <= nsx_op_e'(apb_req.pwdata[`NSX_CMD_OP_LSB +: 4]);
        cmd_q.addr    <= apb_req.pwdata[`NSX_CMD_ADDR_LSB +: 8];
        cmd_q.bit_sel <= apb_req.pwdata[`NSX_CMD_BIT_LSB +: 3];
        cmd_q.imm     <= apb_req.pwdata[`NSX_CMD_IMM_LSB +: 8];
      end
    end
  end

  // accumulator and zero flag; skips, swaps and table reads leave the flag alone
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accum_q <= `NSX_RST_BYTE;
      zero_q  <= 1'b0;
    end
    else if (exec)
    begin
      if (op_nibx)
        accum_q <= swapped;
      else if (op_mskz)
        accum_q <= mem_byte;
      else if (xor_to_a)
        accum_q <= xor_res;
      if (xor_any)
        zero_q <= (xor_res == `NSX_RST_BYTE);
    end
    else if (sw_wr & hit_accum)
      accum_q <= apb_req.pwdata[7:0];
  end

  // program counter: one step per instruction, two when the next one is skipped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_q   <= '0;
      skip_q <= 1'b0;
    end
    else if (exec)
    begin
      skip_q <= do_skip;
      if (!op_table)
        pc_q <= pc_q + PA_W'(1);
    end
    else if (state_q == NSX_ST_DUMMY)
      pc_q <= pc_q + PA_W'(1);
    else if (tab_done)
      pc_q <= pc_q + PA_W'(1);
    else if (sw_wr & hit_pc)
      pc_q <= apb_req.pwdata[PA_W-1:0];
  end

  // table pointers, latch and program memory request
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tptr_lo_q <= `NSX_RST_BYTE;
      tptr_hi_q <= '0;
      tlatch_q  <= `NSX_RST_BYTE;
      pm_addr_q <= '0;
      pm_rd_q   <= 1'b0;
    end
    else
    begin
      pm_rd_q <= exec & op_table;
      if (exec & op_table)
        pm_addr_q <= tab_addr;
      if (tab_done)
        tlatch_q <= pm_rdata[15:8];
      if (sw_wr & hit_tlo)
        tptr_lo_q <= apb_req.pwdata[7:0];
      if (sw_wr & hit_thi)
        tptr_hi_q <= apb_req.pwdata[HP_W-1:0];
    end
  end

  // read mux, registered on the setup cycle so that data is valid in the access phase
  wire logic [31:0] stat_word = {29'h0, skip_q, zero_q, busy};
  wire logic [31:0] rd_mux    = hit_stat ? stat_word :
                                hit_accum  ? {24'h0, accum_q} :
                                hit_tlo    ? {24'h0, tptr_lo_q} :
                                hit_thi    ? 32'(tptr_hi_q) :
                                hit_tlatch ? {24'h0, tlatch_q} :
                                hit_pc   ? 32'(pc_q) :
                                hit_dmem ? {24'h0, dmem_q[dm_apb_idx]} :
                                           32'h0;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (apb_req.psel & ~apb_req.penable)
      prdata <= rd_mux;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // nibble swaps
  AST_SWAP_INPLACE: assert property (exec & op_swap |=>
    dmem_q[$past(dm_idx)] == {$past(mem_byte[3:0]), $past(mem_byte[7:4])} && $stable(zero_q))
    else $error("in-place swap wrong");
  AST_SWAP_ACCUM: assert property (exec & op_nibx |=>
    accum_q == {$past(mem_byte[3:0]), $past(mem_byte[7:4])} && dmem_q[$past(dm_idx)] == $past(mem_byte))
    else $error("swap to accumulator wrong");

  // skips and sequencing
  AST_NULL_SKIP: assert property (exec & op_skz & byte_null |=> state_q == NSX_ST_DUMMY ##1 idle)
    else $error("byte test did not skip");
  AST_SKIP_PC: assert property (exec & do_skip |=> ##1 pc_q == $past(pc_q, 2) + PA_W'(2))
    else $error("skip did not advance pc by two");
  AST_NOSKIP: assert property (exec & ~do_skip & ~op_table |=> idle && pc_q == $past(pc_q) + PA_W'(1))
    else $error("non-skip took too long");
  AST_MOVE_SKIP: assert property (exec & op_mskz |=>
    accum_q == $past(mem_byte) && $stable(zero_q) && (state_q == NSX_ST_DUMMY) == ($past(mem_byte) == 8'h00))
    else $error("move-and-test wrong");
  AST_BIT_SKIP: assert property (exec & op_skbit |=> (state_q == NSX_ST_DUMMY) == $past(bit_null))
    else $error("bit test skip wrong");
  AST_SKIP_NO_FLAG: assert property (exec & (op_skz | op_skbit) |=> $stable(zero_q) && $stable(accum_q))
    else $error("skip test touched flag or accumulator");

  // table reads
  AST_TAB_ADDR: assert property (exec & op_table |=> pm_rd && pm_addr[7:0] == $past(tptr_lo_q))
    else $error("table address wrong");
  AST_TAB_SPEC: assert property (exec & op_tabs |=> pm_addr[PA_W-1:8] == $past(tptr_hi_q))
    else $error("specific page not used");
  AST_TAB_LAST: assert property (exec & op_tabl |=> pm_addr[PA_W-1:8] == {HP_W{1'b1}})
    else $error("last page not used");
  AST_TAB_CUR: assert property (exec & op_tabc |=> pm_addr[PA_W-1:8] == $past(page_cur))
    else $error("current page not used");
  AST_PM_PULSE: assert property (pm_rd |=> !pm_rd)
    else $error("table request longer than one cycle");
  AST_TAB_STORE: assert property (tab_done |=>
    tlatch_q == $past(pm_rdata[15:8]) && dmem_q[$past(dm_idx)] == $past(pm_rdata[7:0]))
    else $error("table data not stored");
  AST_TAB_NO_FLAG: assert property (tab_done |=> $stable(zero_q) && $stable(accum_q))
    else $error("table read touched flag or accumulator");

  // exclusive-or and the zero flag
  AST_XOR_ACC: assert property (exec & op_xora |=> accum_q == ($past(accum_q) ^ $past(mem_byte)))
    else $error("xor to accumulator wrong");
  AST_XORA_MEM_KEPT: assert property (exec & op_xora |=> dmem_q[$past(dm_idx)] == $past(mem_byte))
    else $error("xor to accumulator changed memory");
  AST_EXCLUSIVE_OR_INTO_MEMORY: assert property (exec & op_exclusive_or_into_memory |=>
    dmem_q[$past(dm_idx)] == ($past(accum_q) ^ $past(mem_byte)) && $stable(accum_q))
    else $error("xor into memory wrong");
  AST_XOR_IMM: assert property (exec & op_xori |=> accum_q == ($past(accum_q) ^ $past(cmd_q.imm)))
    else $error("xor immediate wrong");
  AST_ZERO: assert property (exec & xor_any |=> zero_q == ($past(xor_res) == 8'h00))
    else $error("zero flag wrong");

  // main scenarios
  COV_SKIP: cover property (exec & do_skip ##1 state_q == NSX_ST_DUMMY);
  COV_BIT_SKIP: cover property (exec & op_skbit & bit_null ##1 state_q == NSX_ST_DUMMY);
  COV_TABLE: cover property (exec & op_table ##[1:20] tab_done);
  COV_TABLE_LAST: cover property (exec & op_tabl ##[1:20] tab_done);
  COV_XOR_ZERO: cover property (exec & xor_any ##1 zero_q);

endmodule : nsx_exec

/* File: verif/testbench.sv */
// Purpose: self-checking bench for the nibble/skip/table/xor executor
// Assumes: pready tied high, program memory answered here by a delayed responder
// Notes:   every op code but 5 (run as 7) is run once in order, then at random with forced zero corners
`timescale 1ns/1ps
`include "nsx_defines.svh"

module testbench;
  import nsx_pkg::*;

  logic                  pclk;
  logic                  presetn;
  nsx_apb_req_s          apb_req;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [11:0]           pm_addr;
  logic                  pm_rd;
  logic [15:0]           pm_rdata;
  logic                  pm_rvalid;
  logic                  busy;
  int                    miscompares;
  int                    checks_done;
  int                    pend;
  int                    pm_reqs;
  int                    pm_delay;
  logic [7:0]            accum_m;
  logic [7:0]            tlo_m;
  logic [7:0]            tlatch_m;
  logic [7:0]            dm_m;
  logic [3:0]            thi_m;
  logic [11:0]           pc_m;
  logic                  z_m;
  logic                  skip_m;

  nsx_exec DUT (
    .pclk      (pclk),
    .presetn   (presetn),
    .apb_req   (apb_req),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .pm_addr   (pm_addr),
    .pm_rd     (pm_rd),
    .pm_rdata  (pm_rdata),
    .pm_rvalid (pm_rvalid),
    .busy      (busy)
  );

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  function automatic logic [15:0] pm_word(input logic [11:0] a);
    return {a[7:0] ^ 8'h3c, a[11:4]};
  endfunction : pm_word

  function automatic logic [7:0] swap(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction : swap

  // the responder scrambles its data outside the valid cycle so a stale read cannot match
  always @(posedge pclk)
  begin
    pm_rvalid <= 1'b0;
    pm_rdata  <= ~pm_rdata;
    if (pm_rd === 1'b1)
    begin
      pend    <= pm_delay;
      pm_reqs <= pm_reqs + 1;
    end
    else if (pend > 1)
      pend <= pend - 1;
    else if (pend == 1)
    begin
      pm_rvalid <= 1'b1;
      pm_rdata  <= pm_word(pm_addr);
      pend      <= 0;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask : rd_chk

  task automatic run_op(input logic [3:0] op, input logic [3:0] a, input logic [2:0] b,
                        input logic [7:0] im, input bit poke);
    int          n;
    int          reqs;
    logic [31:0] rd;
    logic        err;
    logic [11:0] pa;
    logic [15:0] w;
    n = 0;
    pa = 12'h0;
    apb(1'b1, `NSX_OFS_DMEM + {6'h0, a, 2'b00}, {24'h0, dm_m}, rd, err);
    apb(1'b1, `NSX_OFS_ACCUM, {24'h0, accum_m}, rd, err);
    apb(1'b1, `NSX_OFS_TPTR_LO, {24'h0, tlo_m}, rd, err);
    apb(1'b1, `NSX_OFS_TPTR_HI, {28'h0, thi_m}, rd, err);
    apb(1'b1, `NSX_OFS_PC, {20'h0, pc_m}, rd, err);
    pm_delay = poke ? 8 : 1 + int'($urandom % 3);
    reqs = pm_reqs;
    apb(1'b1, `NSX_OFS_CMD, {8'h0, im, 1'b0, b, 4'h0, a, op}, rd, err);
    if (poke)
    begin
      apb(1'b1, `NSX_OFS_ACCUM, 32'hff, rd, err);
      chk({31'h0, err}, 32'h1);
    end
    #1;
    while (busy === 1'b1)
    begin
      n++;
      @(posedge pclk);
      #1;
    end
    skip_m = 1'b0;
    case (op)
      4'd0: dm_m = swap(dm_m);
      4'd1: accum_m = swap(dm_m);
      4'd2: skip_m = (dm_m == 8'h00);
      4'd3: begin accum_m = dm_m; skip_m = (dm_m == 8'h00); end
      4'd4: skip_m = ~dm_m[b];
      4'd5: pa = {thi_m, tlo_m};
      4'd6: pa = {pc_m[11:8], tlo_m};
      4'd7: pa = {4'hf, tlo_m};
      4'd8: begin accum_m = accum_m ^ dm_m; z_m = (accum_m == 8'h00); end
      4'd9: begin dm_m = accum_m ^ dm_m; z_m = (dm_m == 8'h00); end
      4'd10: begin accum_m = accum_m ^ im; z_m = (accum_m == 8'h00); end
      default: ;
    endcase
    if (op >= 4'd5 && op <= 4'd7)
    begin
      w = pm_word(pa);
      dm_m = w[7:0];
      tlatch_m = w[15:8];
      chk({20'h0, pm_addr}, {20'h0, pa});
    end
    else if (!poke)
      chk(n, skip_m ? 2 : 1);
    chk(pm_reqs - reqs, (op >= 4'd5 && op <= 4'd7) ? 1 : 0);
    pc_m = pc_m + (skip_m ? 12'd2 : 12'd1);
    rd_chk(`NSX_OFS_ACCUM, {24'h0, accum_m}, 1'b0);
    rd_chk(`NSX_OFS_DMEM + {6'h0, a, 2'b00}, {24'h0, dm_m}, 1'b0);
    rd_chk(`NSX_OFS_STAT, {29'h0, skip_m, z_m, 1'b0}, 1'b0);
    rd_chk(`NSX_OFS_TLATCH, {24'h0, tlatch_m}, 1'b0);
    rd_chk(`NSX_OFS_PC, {20'h0, pc_m}, 1'b0);
  endtask : run_op

  initial
  begin
    #(25 * 90000);
    miscompares++;
    final_report();
  end

  initial
  begin
    logic [31:0] rd;
    logic        err;
    logic [3:0]  op;
    int          r;
    void'($urandom(32'h4d4566b7));
    apb_req = '0;
    presetn = 1'b0;
    pm_rdata = 16'h0;
    pm_rvalid = 1'b0;
    pend = 0;
    pm_delay = 1;
    miscompares = 0;
    checks_done = 0;
    pm_reqs = 0;
    {accum_m, tlo_m, tlatch_m, dm_m, thi_m, pc_m, z_m, skip_m} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`NSX_OFS_ACCUM, 32'h0, 1'b0);
    rd_chk(`NSX_OFS_TLATCH, 32'h0, 1'b0);
    rd_chk(`NSX_OFS_PC, 32'h0, 1'b0);
    rd_chk(`NSX_OFS_STAT, 32'h0, 1'b0);
    rd_chk(12'h100, 32'h0, 1'b1);
    apb(1'b1, `NSX_OFS_STAT, 32'h7, rd, err);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, `NSX_OFS_TLATCH, 32'hff, rd, err);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 220; i++)
    begin
      r = int'($urandom % 4);
      op = (i < 16) ? i[3:0] : 4'($urandom % 16);
      // a write while busy is only sure to land inside the long table wait
      if ((i % 37) == 5)
        op = 4'd5 + 4'(i % 3);
      dm_m = (r == 0) ? 8'h00 : 8'($urandom);
      accum_m = (r == 1) ? dm_m : 8'($urandom);
      tlo_m = 8'($urandom);
      thi_m = 4'($urandom);
      pc_m = {4'($urandom), 8'($urandom % 240)};
      run_op(op, 4'($urandom), 3'($urandom), (r == 1) ? accum_m : 8'($urandom), (i % 37) == 5);
    end
    final_report();
  end
endmodule : testbench
